//--- hw/tsp_regs_top.sv
// Two-wire slave register bank of the temperature sensor
//
// Function
// - Keep an eight-bit pointer; its two low bits choose the data register.
// - Pointer select bits reset to 00, so a plain read returns temperature.
// - Select 00 temperature, 01 configuration, 10 low limit, 11 high limit.
// - Rate code 00,01,10,11 gives 0.25, 1, 4, 8 conversions per second.
// - Eight fixed address options let eight sensors share one bus.
// - Individually addressed transfers read or write one register at a time.
// - Answer the global group command so all sensors act together.
// - Only pull data and clock lines low, never drive them high.
// - Temperature is eight-bit two's complement, zero until the first conversion.
// - Configuration resets to 00000010: id, rate, flags, latch, mode.
// - Commit a written value only after a full byte, MSB first.
// - High limit resets to +60, low limit to -10 degrees.
`timescale 1ns/1ns
`default_nettype none
module tsp_regs_top #(
  parameter int unsigned P_RATE0_CYC = tsp_pkg::RATE0_CYC,
  parameter int unsigned P_RATE1_CYC = tsp_pkg::RATE1_CYC,
  parameter int unsigned P_RATE2_CYC = tsp_pkg::RATE2_CYC,
  parameter int unsigned P_RATE3_CYC = tsp_pkg::RATE3_CYC
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [2:0] i_addr_strap,
  input wire logic i_conv_done,
  input wire logic [7:0] i_conv_temp,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_scl_out,
  output logic o_scl_oe,
  output logic o_conv_start,
  output logic [1:0] o_rate_code,
  output logic [1:0] o_op_mode,
  output logic o_over_flag,
  output logic o_under_flag
);
  tsp_line_if ln ();
  tsp_pkg::tsp_state_e state;
  logic [3:0] cnt;
  logic [7:0] sr;
  logic [7:0] tx;
  logic rw;
  logic nack;
  logic sda_oe;
  logic [2:0] addr_low;
  logic strap_taken;
  logic [7:0] register_select;
  logic [7:0] temperature_result;
  logic [7:0] configuration;
  logic [7:0] low_limit;
  logic [7:0] high_limit;
  logic timer_fire;

  // ----------------------------------------------------------------
  // Line events and conversion pacing
  // ----------------------------------------------------------------
  tsp_line_watch u_watch (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .ln(ln)
  );

  tsp_rate_timer #(
    .P_RATE0_CYC(P_RATE0_CYC),
    .P_RATE1_CYC(P_RATE1_CYC),
    .P_RATE2_CYC(P_RATE2_CYC),
    .P_RATE3_CYC(P_RATE3_CYC)
  ) u_timer (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_rate(configuration[tsp_pkg::CFG_RATE_HI:tsp_pkg::CFG_RATE_LO]),
    .i_continuous(configuration[tsp_pkg::CFG_MODE_HI]),
    .o_fire(timer_fire)
  );

  // ----------------------------------------------------------------
  // Byte framing decode
  // ----------------------------------------------------------------
  logic rx_state;
  logic byte_end;
  logic [6:0] my_addr;
  logic addr_hit;
  logic ptr_commit;
  logic wr_commit;
  logic [1:0] sel;
  logic [7:0] rd_word;
  logic load_tx;
  assign rx_state = (state == tsp_pkg::ST_ADDR) || (state == tsp_pkg::ST_PTR) ||
                    (state == tsp_pkg::ST_WR);
  assign byte_end = rx_state && ln.scl_fall && (cnt == tsp_pkg::BITS_PER_BYTE);
  assign my_addr = tsp_pkg::ADDR_BASE | {4'h0, addr_low};
  assign addr_hit = (sr[7:1] == my_addr) || (sr[7:1] == tsp_pkg::GLOBAL_ADDR);
  assign ptr_commit = byte_end && (state == tsp_pkg::ST_PTR);
  assign wr_commit = byte_end && (state == tsp_pkg::ST_WR);
  assign sel = register_select[1:0];

  // Read data select
  assign rd_word = (sel == tsp_pkg::SEL_TEMP) ? temperature_result :
                   (sel == tsp_pkg::SEL_CFG) ? configuration :
                   (sel == tsp_pkg::SEL_LOW) ? low_limit : high_limit;
  assign load_tx = ln.scl_fall && ((state == tsp_pkg::ST_AACK && rw) ||
                   (state == tsp_pkg::ST_RACK && !nack));

  // ----------------------------------------------------------------
  // Serial engine: address, pointer, write and read bytes
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= tsp_pkg::ST_IDLE;
      cnt <= 4'h0;
      sr <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      nack <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ln.stop) begin
      state <= tsp_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end else if (ln.start) begin
      state <= tsp_pkg::ST_ADDR;
      cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (load_tx) begin
      // First data bit goes out as a pull-down when it is zero
      state <= tsp_pkg::ST_RD;
      sda_oe <= ~rd_word[7];
      tx <= {rd_word[6:0], 1'b0};
      cnt <= 4'h1;
    end else begin
      unique case (state)
        tsp_pkg::ST_IDLE: begin
          cnt <= 4'h0;
        end
        tsp_pkg::ST_ADDR, tsp_pkg::ST_PTR, tsp_pkg::ST_WR: begin
          if (ln.scl_rise) begin
            sr <= {sr[6:0], ln.sda};
            cnt <= cnt + 4'h1;
          end else if (byte_end) begin
            cnt <= 4'h0;
            if (state == tsp_pkg::ST_ADDR) begin
              rw <= sr[0];
              sda_oe <= addr_hit;
              state <= addr_hit ? tsp_pkg::ST_AACK : tsp_pkg::ST_IDLE;
            end else begin
              sda_oe <= 1'b1;
              state <= (state == tsp_pkg::ST_PTR) ? tsp_pkg::ST_PACK : tsp_pkg::ST_WACK;
            end
          end
        end
        tsp_pkg::ST_AACK: begin
          if (ln.scl_fall) begin
            sda_oe <= 1'b0;
            state <= tsp_pkg::ST_PTR;
          end
        end
        tsp_pkg::ST_PACK, tsp_pkg::ST_WACK: begin
          if (ln.scl_fall) begin
            sda_oe <= 1'b0;
            state <= tsp_pkg::ST_WR;
          end
        end
        tsp_pkg::ST_RD: begin
          if (ln.scl_fall && cnt == tsp_pkg::BITS_PER_BYTE) begin
            sda_oe <= 1'b0;
            cnt <= 4'h0;
            state <= tsp_pkg::ST_RACK;
          end else if (ln.scl_fall) begin
            sda_oe <= ~tx[7];
            tx <= {tx[6:0], 1'b0};
            cnt <= cnt + 4'h1;
          end
        end
        tsp_pkg::ST_RACK: begin
          if (ln.scl_rise) begin
            nack <= ln.sda;
          end else if (ln.scl_fall) begin
            state <= tsp_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= tsp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address strap, caught once after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      addr_low <= 3'h0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      addr_low <= i_addr_strap;
      strap_taken <= 1'b1;
    end
  end

  // Pointer register, kept across transactions
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      register_select <= tsp_pkg::PTR_RESET;
    end else if (ptr_commit) begin
      register_select <= sr;
    end
  end

  // ----------------------------------------------------------------
  // Data registers; temperature is loaded only by the converter
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      temperature_result <= tsp_pkg::TEMP_RESET;
      low_limit <= tsp_pkg::LOW_RESET;
      high_limit <= tsp_pkg::HIGH_RESET;
    end else begin
      if (i_conv_done) temperature_result <= i_conv_temp;
      if (wr_commit && sel == tsp_pkg::SEL_LOW) low_limit <= sr;
      if (wr_commit && sel == tsp_pkg::SEL_HIGH) high_limit <= sr;
    end
  end

  // ----------------------------------------------------------------
  // Configuration next value: flags, latch, rate and mode
  // ----------------------------------------------------------------
  logic cfg_wr;
  logic cfg_rd;
  logic over_ev;
  logic under_ev;
  logic in_window;
  logic flag_clr;
  logic [1:0] mode;
  logic oneshot_go;
  logic [1:0] next_rate;
  logic next_over;
  logic next_under;
  logic next_latch;
  logic [1:0] next_mode;
  assign cfg_wr = wr_commit && (sel == tsp_pkg::SEL_CFG);
  assign cfg_rd = load_tx && (sel == tsp_pkg::SEL_CFG);
  assign mode = configuration[tsp_pkg::CFG_MODE_HI:tsp_pkg::CFG_MODE_LO];
  assign over_ev = i_conv_done && ($signed(i_conv_temp) > $signed(high_limit));
  assign under_ev = i_conv_done && ($signed(i_conv_temp) < $signed(low_limit));
  assign in_window = i_conv_done && !over_ev && !under_ev;
  assign flag_clr = cfg_rd || (in_window && !configuration[tsp_pkg::CFG_LATCH]);
  assign oneshot_go = cfg_wr && (mode == tsp_pkg::MODE_SHUT) &&
                      (sr[1:0] == tsp_pkg::MODE_ONESHOT);
  assign next_rate = cfg_wr ? sr[tsp_pkg::CFG_RATE_HI:tsp_pkg::CFG_RATE_LO] :
                     configuration[tsp_pkg::CFG_RATE_HI:tsp_pkg::CFG_RATE_LO];
  // A flag event wins over a clear in the same cycle
  assign next_over = over_ev || (configuration[tsp_pkg::CFG_OVER] && !flag_clr);
  assign next_under = under_ev || (configuration[tsp_pkg::CFG_UNDER] && !flag_clr);
  assign next_latch = cfg_wr ? sr[tsp_pkg::CFG_LATCH] : configuration[tsp_pkg::CFG_LATCH];
  assign next_mode = cfg_wr ? sr[1:0] :
                     (i_conv_done && mode == tsp_pkg::MODE_ONESHOT) ? tsp_pkg::MODE_SHUT :
                     mode;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      configuration <= tsp_pkg::CFG_RESET;
    end else begin
      configuration <= {configuration[tsp_pkg::CFG_ID], next_rate, next_over,
                        next_under, next_latch, next_mode};
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers: open drain only, clock never stretched
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sda_out <= 1'b0;
      o_scl_out <= 1'b0;
      o_scl_oe <= 1'b0;
      o_conv_start <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
      o_scl_out <= 1'b0;
      o_scl_oe <= 1'b0;
      o_conv_start <= timer_fire || oneshot_go;
    end
  end

  assign o_sda_oe = sda_oe;
  assign o_rate_code = configuration[tsp_pkg::CFG_RATE_HI:tsp_pkg::CFG_RATE_LO];
  assign o_op_mode = mode;
  assign o_over_flag = configuration[tsp_pkg::CFG_OVER];
  assign o_under_flag = configuration[tsp_pkg::CFG_UNDER];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence addr_byte_s;
    byte_end && state == tsp_pkg::ST_ADDR;
  endsequence

  sequence data_byte_s;
    byte_end && state == tsp_pkg::ST_WR;
  endsequence

  a_ptr_hold: assert property (!ptr_commit |=> $stable(register_select))
    else $error("Pointer changed without a pointer byte");
  a_read_select: assert property (load_tx && sel == tsp_pkg::SEL_TEMP
    |=> state == tsp_pkg::ST_RD && sda_oe == ~$past(temperature_result[7]))
    else $error("Read did not start with the temperature register");
  a_temp_readonly: assert property ((data_byte_s ##0 sel == tsp_pkg::SEL_TEMP
    && !i_conv_done) |=> $stable(temperature_result) && sda_oe)
    else $error("Write to temperature changed it or was not acknowledged");
  a_commit_end: assert property ($changed(low_limit) |-> $past(wr_commit)
    && $past(sel) == tsp_pkg::SEL_LOW && low_limit == $past(sr))
    else $error("Low limit changed outside a completed data byte");
  a_pull_only: assert property (!o_sda_out && !o_scl_oe && !o_scl_out)
    else $error("A serial line was driven high or the clock was pulled");
  a_addr_miss: assert property ((addr_byte_s ##0 !addr_hit)
    |=> state == tsp_pkg::ST_IDLE && !sda_oe)
    else $error("Foreign address was acknowledged");
  a_global_ack: assert property ((addr_byte_s ##0 sr[7:1] == tsp_pkg::GLOBAL_ADDR)
    |=> sda_oe ##1 (sda_oe || ln.scl_fall || state != tsp_pkg::ST_AACK))
    else $error("Global group command was not acknowledged");
  a_flag_set: assert property (over_ev |=> o_over_flag)
    else $error("Over flag lost on a conversion event");
endmodule : tsp_regs_top
`default_nettype wire

//--- hw/tsp_pkg.sv
// Constants, field layout and state codes of the sensor register block
package tsp_pkg;
  // ----------------------------------------------------------------
  // Data register select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_TEMP = 2'h0;
  localparam logic [1:0] SEL_CFG = 2'h1;
  localparam logic [1:0] SEL_LOW = 2'h2;
  localparam logic [1:0] SEL_HIGH = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h02;
  localparam logic [7:0] LOW_RESET = 8'hf6;  // -10 degrees
  localparam logic [7:0] HIGH_RESET = 8'h3c; // +60 degrees

  // ----------------------------------------------------------------
  // Configuration field positions
  // ----------------------------------------------------------------
  localparam int CFG_ID = 7;
  localparam int CFG_RATE_HI = 6;
  localparam int CFG_RATE_LO = 5;
  localparam int CFG_OVER = 4;
  localparam int CFG_UNDER = 3;
  localparam int CFG_LATCH = 2;
  localparam int CFG_MODE_HI = 1;
  localparam int CFG_MODE_LO = 0;
  localparam logic [1:0] MODE_SHUT = 2'h0;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;

  // ----------------------------------------------------------------
  // Bus addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_BASE = 7'h70;
  localparam logic [6:0] GLOBAL_ADDR = 7'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // Conversion periods per rate code
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned RATE0_MS = 4000; // 0.25 per second
  localparam int unsigned RATE1_MS = 1000; // 1 per second
  localparam int unsigned RATE2_MS = 250;  // 4 per second
  localparam int unsigned RATE3_MS = 125;  // 8 per second
  localparam int unsigned RATE0_CYC = CLK_HZ / 1000 * RATE0_MS;
  localparam int unsigned RATE1_CYC = CLK_HZ / 1000 * RATE1_MS;
  localparam int unsigned RATE2_CYC = CLK_HZ / 1000 * RATE2_MS;
  localparam int unsigned RATE3_CYC = CLK_HZ / 1000 * RATE3_MS;

  // ----------------------------------------------------------------
  // Serial engine states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h2,
    ST_PTR = 4'h3,
    ST_PACK = 4'h4,
    ST_WR = 4'h5,
    ST_WACK = 4'h6,
    ST_RD = 4'h7,
    ST_RACK = 4'h8
  } tsp_state_e;
endpackage : tsp_pkg

//--- hw/tsp_line_if.sv
// Serial line events passed from the line watcher to the register engine
`timescale 1ns/1ns
`default_nettype none
interface tsp_line_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;
  modport src (output scl_rise, output scl_fall, output start, output stop, output sda);
  modport snk (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface : tsp_line_if
`default_nettype wire

//--- hw/tsp_line_watch.sv
// Clock edge and start/stop detection on the two serial lines
`timescale 1ns/1ns
`default_nettype none
module tsp_line_watch (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  tsp_line_if.src ln
);
  logic scl_q;
  logic sda_q;

  // ----------------------------------------------------------------
  // Previous line levels, idle high
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  // Events: data moves while clock high mark start and stop
  assign ln.scl_rise = i_scl & ~scl_q;
  assign ln.scl_fall = ~i_scl & scl_q;
  assign ln.start = i_scl & scl_q & sda_q & ~i_sda;
  assign ln.stop = i_scl & scl_q & ~sda_q & i_sda;
  assign ln.sda = i_sda;
endmodule : tsp_line_watch
`default_nettype wire

//--- hw/tsp_rate_timer.sv
// Conversion request timer paced by the rate code
`timescale 1ns/1ns
`default_nettype none
module tsp_rate_timer #(
  parameter int unsigned P_RATE0_CYC = tsp_pkg::RATE0_CYC,
  parameter int unsigned P_RATE1_CYC = tsp_pkg::RATE1_CYC,
  parameter int unsigned P_RATE2_CYC = tsp_pkg::RATE2_CYC,
  parameter int unsigned P_RATE3_CYC = tsp_pkg::RATE3_CYC
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [1:0] i_rate,
  input wire logic i_continuous,
  output logic o_fire
);
  logic [26:0] cnt;
  logic [26:0] period_m1;

  // Rate code to reload value
  assign period_m1 = (i_rate == 2'h0) ? 27'(P_RATE0_CYC - 1) :
                     (i_rate == 2'h1) ? 27'(P_RATE1_CYC - 1) :
                     (i_rate == 2'h2) ? 27'(P_RATE2_CYC - 1) :
                     27'(P_RATE3_CYC - 1);

  // ----------------------------------------------------------------
  // Countdown, fires at once after reset while continuous
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= 27'h0;
      o_fire <= 1'b0;
    end else if (cnt == 27'h0) begin
      o_fire <= i_continuous;
      cnt <= i_continuous ? period_m1 : 27'h0;
    end else begin
      o_fire <= 1'b0;
      cnt <= cnt - 27'h1;
    end
  end

  a_rate_reload: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (cnt == 27'h0 && i_continuous) |=> (o_fire && cnt == $past(period_m1)))
    else $error("Rate timer did not reload with the selected period");
endmodule : tsp_rate_timer
`default_nettype wire

//--- sim/tsp_master_model.sv
// Two-wire bus master model driving the sensor's serial lines
`timescale 1ns/1ns
`default_nettype none
module tsp_master_model (
  input wire logic i_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_low,
  output logic o_sda_low
);
  // Cycles per clock phase; the slave needs two at least
  localparam int HALF = 4;

  // Lines released at start, so pull-ups hold them high
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end

  // Wait n edges, then change just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  // Start or repeated start, from idle or from clock low
  task automatic start();
    o_sda_low = 1'b0;
    tick(HALF);
    o_scl_low = 1'b0;
    tick(HALF);
    o_sda_low = 1'b1;
    tick(HALF);
    o_scl_low = 1'b1;
    tick(HALF);
  endtask : start

  // Stop: data rises while the clock is high
  task automatic stop();
    o_sda_low = 1'b1;
    tick(HALF);
    o_scl_low = 1'b0;
    tick(HALF);
    o_sda_low = 1'b0;
    tick(HALF);
  endtask : stop

  // One clock pulse: data set in the low phase, sampled at the end of the high phase
  task automatic clk_bit(input logic b, output logic s);
    o_sda_low = ~b;
    tick(HALF);
    o_scl_low = 1'b0;
    tick(HALF);
    s = i_sda;
    o_scl_low = 1'b1;
    tick(HALF);
  endtask : clk_bit

  // Sends n bits MSB first; a whole byte also clocks the ack bit
  task automatic wr_byte(input logic [7:0] d, input int n, output logic nack);
    logic s;
    nack = 1'b1;
    for (int i = 7; i > 7 - n; i--) begin
      clk_bit(d[i], s);
    end
    if (n == 8) begin
      clk_bit(1'b1, nack);
    end
  endtask : wr_byte

  // Reads one byte, then acks or ends with a nack
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(last, s);
  endtask : rd_byte
endmodule : tsp_master_model
`default_nettype wire

//--- sim/tb.sv
// Self-checking testbench of the sensor register block
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [6:0] DEV = tsp_pkg::ADDR_BASE | 7'h05;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic conv_done = 1'b0;
  logic [7:0] conv_temp = 8'h00;
  logic sda_out, sda_oe, scl_out, scl_oe, conv_start, over_flag, under_flag;
  logic [1:0] rate_code, op_mode;
  logic m_scl_low, m_sda_low;
  wire w_scl = ~(m_scl_low | scl_oe);
  wire w_sda = ~(m_sda_low | sda_oe);
  int errors = 0;
  int check_count = 0;
  int starts = 0;

  // Clock generation
  always #20 clk = ~clk;

  tsp_regs_top #(.P_RATE0_CYC(128), .P_RATE1_CYC(32), .P_RATE2_CYC(8), .P_RATE3_CYC(4)) u_dut (
    .i_clk(clk), .i_resetn(resetn), .i_scl(w_scl), .i_sda(w_sda),
    .i_addr_strap(3'h5), .i_conv_done(conv_done), .i_conv_temp(conv_temp),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_scl_out(scl_out), .o_scl_oe(scl_oe),
    .o_conv_start(conv_start), .o_rate_code(rate_code), .o_op_mode(op_mode),
    .o_over_flag(over_flag), .o_under_flag(under_flag));

  tsp_master_model u_mst (
    .i_clk(clk), .i_scl(w_scl), .i_sda(w_sda), .o_scl_low(m_scl_low), .o_sda_low(m_sda_low));

  // Compare and report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Lines only ever pulled low, clock never stretched
  always @(posedge clk) begin
    if (resetn) begin
      chk({5'h00, sda_out, scl_out, scl_oe}, 8'h00);
    end
  end

  // Conversion requests seen, counted one edge after each pulse
  always @(posedge clk) begin
    if (conv_start === 1'b1) begin
      starts++;
    end
  end

  // Scaled conversion period per rate code, 32:8:2:1 like 0.25, 1, 4 and 8 per second
  function automatic int per(input int rc);
    return (rc == 0) ? 128 : (rc == 1) ? 32 : (rc == 2) ? 8 : 4;
  endfunction : per

  // Pointer write followed by one data byte
  task automatic reg_wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                        output logic nack);
    logic n0, n1, n2;
    u_mst.start();
    u_mst.wr_byte({a, 1'b0}, 8, n0);
    u_mst.wr_byte(p, 8, n1);
    u_mst.wr_byte(d, 8, n2);
    u_mst.stop();
    nack = n0 | n1 | n2;
  endtask : reg_wr

  // Pointer only
  task automatic set_ptr(input logic [6:0] a, input logic [7:0] p);
    logic n0, n1;
    u_mst.start();
    u_mst.wr_byte({a, 1'b0}, 8, n0);
    u_mst.wr_byte(p, 8, n1);
    u_mst.stop();
    chk({6'h00, n0, n1}, 8'h00);
  endtask : set_ptr

  // Read of the selected register; the byte is skipped when not acked
  task automatic reg_rd(input logic [6:0] a, output logic [7:0] d, output logic nack);
    d = 8'h00;
    u_mst.start();
    u_mst.wr_byte({a, 1'b1}, 8, nack);
    if (nack === 1'b0) begin
      u_mst.rd_byte(1'b1, d);
    end
    u_mst.stop();
  endtask : reg_rd

  // Reset values of every register
  task automatic t_reset();
    logic [7:0] d;
    logic n;
    reg_rd(DEV, d, n);
    chk(d, 8'h00);
    chk({7'h00, n}, 8'h00);
    chk({6'h00, op_mode}, 8'h02);
    set_ptr(DEV, 8'h01);
    reg_rd(DEV, d, n);
    chk(d, 8'h02);
    set_ptr(DEV, 8'h02);
    reg_rd(DEV, d, n);
    chk(d, 8'hf6);
    set_ptr(DEV, 8'h03);
    reg_rd(DEV, d, n);
    chk(d, 8'h3c);
  endtask : t_reset

  // Gap in cycles from one conversion request to the next
  task automatic pace(input int rc);
    int k;
    k = 0;
    while (conv_start !== 1'b1 && k < 300) begin
      @(posedge clk) #1;
      k++;
    end
    k = 1;
    @(posedge clk) #1;
    while (conv_start !== 1'b1 && k < 300) begin
      @(posedge clk) #1;
      k++;
    end
    chk(8'(k), 8'(per(rc)));
  endtask : pace

  // Every conversion rate code written and read back
  task automatic t_rates();
    logic [7:0] d;
    logic n;
    for (int rc = 3; rc >= 0; rc--) begin
      reg_wr(DEV, 8'h01, {1'b0, 2'(rc), 5'h02}, n);
      chk({6'h00, rate_code}, 8'(rc));
      reg_rd(DEV, d, n);
      chk(d, {1'b0, 2'(rc), 5'h02});
      pace(rc);
    end
  endtask : t_rates

  // A conversion result, read twice without a new pointer
  task automatic t_conv();
    logic [7:0] d;
    logic n;
    set_ptr(DEV, 8'h00);
    @(posedge clk) #1;
    conv_done = 1'b1;
    conv_temp = 8'he7;
    @(posedge clk) #1;
    conv_done = 1'b0;
    repeat (2) begin
      reg_rd(DEV, d, n);
      chk(d, 8'he7);
    end
    chk({6'h00, over_flag, under_flag}, 8'h01);
    reg_wr(DEV, 8'h00, 8'h55, n);
    chk({7'h00, n}, 8'h00);
    reg_rd(DEV, d, n);
    chk(d, 8'he7);
  endtask : t_conv

  // Limits, a cut-short byte, the group address and a foreign address
  task automatic t_limits();
    logic [7:0] d;
    logic n;
    reg_wr(DEV, 8'h02, 8'h05, n);
    reg_rd(DEV, d, n);
    chk(d, 8'h05);
    u_mst.start();
    u_mst.wr_byte({DEV, 1'b0}, 8, n);
    u_mst.wr_byte(8'h02, 8, n);
    u_mst.wr_byte(8'hff, 4, n);
    u_mst.stop();
    reg_rd(DEV, d, n);
    chk(d, 8'h05);
    reg_wr(tsp_pkg::GLOBAL_ADDR, 8'h03, 8'h4b, n);
    chk({7'h00, n}, 8'h00);
    reg_rd(DEV, d, n);
    chk(d, 8'h4b);
    reg_rd(tsp_pkg::GLOBAL_ADDR, d, n);
    chk(d, 8'h4b);
    reg_rd(DEV ^ 7'h01, d, n);
    chk({7'h00, n}, 8'h01);
  endtask : t_limits

  // Shutdown, one-shot request, its result ending the one-shot and clearing the flags
  task automatic t_oneshot();
    logic [7:0] d;
    logic n;
    int s0;
    reg_wr(DEV, 8'h01, 8'h00, n);
    chk({6'h00, op_mode}, 8'h00);
    s0 = starts;
    reg_wr(DEV, 8'h01, 8'h01, n);
    chk(8'(starts - s0), 8'h01);
    chk({6'h00, op_mode}, 8'h01);
    @(posedge clk) #1;
    conv_done = 1'b1;
    conv_temp = 8'h19;
    @(posedge clk) #1;
    conv_done = 1'b0;
    chk({4'h0, op_mode, over_flag, under_flag}, 8'h00);
    reg_rd(DEV, d, n);
    chk(d, 8'h00);
  endtask : t_oneshot

  // Verdict and end of run
  task automatic results();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, conv_start}, 8'h01);
    @(posedge clk) #1;
    t_reset();
    t_rates();
    t_conv();
    t_limits();
    t_oneshot();
    results();
  end

  // Watchdog well beyond the expected run of about 9000 cycles
  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    results();
  end
endmodule : tb
`default_nettype wire
